//--- design/eaf_top.sv
`timescale 1ns/10ps
`include "eaf_defs.svh"
module eaf_top
  import eaf_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               arst_n,
  // active power from the low-pass stage
  input  wire logic signed [19:0] power_lowpass,
  // host register writes
  input  wire logic               wr_offset_trim,
  input  wire logic               wr_pulse_divider,
  input  wire logic [11:0]        wr_data,
  // mode and interrupt enable bits
  input  wire logic [1:0]         waveform_src_sel,
  input  wire logic [1:0]         waveform_rate_select,
  input  wire logic               sample_ready_enable,
  input  wire logic               half_full_enable,
  input  wire logic               overflow_enable,
  // status clears and sample acknowledge
  input  wire logic               clear_half_full,
  input  wire logic               clear_overflow,
  input  wire logic               sample_ack,
  // register readback
  output logic [39:0]             energy_total,
  output logic [11:0]             power_offset_trim,
  output logic [11:0]             pulse_rate_divider,
  output logic [23:0]             waveform_sample,
  output logic                    half_full_flag,
  output logic                    overflow_flag,
  output logic                    sample_pending,
  // open-drain interrupt request and calibration pulse
  output logic                    irq_out,
  output logic                    irq_oe_n,
  output logic                    calibration_pulse_out
);
  localparam eaf_main_st_t MAIN_RST = '{pdiv: `EAF_PDIV_RST, irq_oe_n: 1'b1, default: '0};

  eaf_main_st_t s;
  eaf_main_st_t next_s;
  logic         upd_tick;
  logic         smp_tick;
  logic [23:0]  power_corr;
  logic [43:0]  energy_sum;
  logic         half_now;
  logic         ovf_now;

  // power scaled to trim resolution plus signed trim
  function automatic logic [23:0] trim_power(input logic [19:0] p, input logic [11:0] off);
    trim_power = {p, 4'h0} + {{12{off[11]}}, off};
  endfunction

  // update and sample enables
  eaf_rate_gen u_rate (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .rate_sel (waveform_rate_select),
    .upd_tick (upd_tick),
    .smp_tick (smp_tick)
  );

  // divided calibration pulse
  eaf_pulse_div u_cf (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .msb_rise  (s.msb_rise),
    .div_val   (s.pdiv),
    .pulse_out (calibration_pulse_out)
  );

  // corrected power and accumulator events
  assign power_corr = trim_power(power_lowpass, s.offset);
  assign energy_sum = s.energy + {{20{power_corr[23]}}, power_corr};
  assign half_now = energy_sum[43] ^ energy_sum[42];
  assign ovf_now = (~s.energy[43] & ~power_corr[23] & energy_sum[43]) |
                   (s.energy[43] & power_corr[23] & ~energy_sum[43]);

  // accumulators, flags, waveform and host writes
  always_comb begin
    next_s = s;
    next_s.msb_rise = 1'b0;
    if (upd_tick) begin
      // natural two's complement wrap gives the roll-over
      next_s.energy = energy_sum;
      next_s.freq = s.freq + {{4{power_corr[23]}}, power_corr};
      next_s.msb_rise = ~s.freq[27] & next_s.freq[27];
    end
    // clears first so a same-cycle event wins
    if (clear_half_full) begin
      next_s.hf_flag = 1'b0;
    end
    if (clear_overflow) begin
      next_s.ovf_flag = 1'b0;
    end
    if (sample_ack) begin
      next_s.smp_pend = 1'b0;
    end
    if (upd_tick) begin
      next_s.in_half = half_now;
      if (half_now && !s.in_half) begin
        next_s.hf_flag = 1'b1;
      end
      if (ovf_now) begin
        next_s.ovf_flag = 1'b1;
      end
    end
    // waveform load of active power, right-justified and sign-extended
    if (smp_tick && waveform_src_sel == `EAF_SRC_POWER && sample_ready_enable) begin
      next_s.wave = {{4{power_corr[23]}}, power_corr[23:4]};
      next_s.smp_pend = 1'b1;
    end
    if (wr_offset_trim) begin
      next_s.offset = wr_data;
    end
    if (wr_pulse_divider) begin
      next_s.pdiv = wr_data;
    end
    // open-drain request: enable low pulls the line low
    next_s.irq_out = 1'b0;
    next_s.irq_oe_n = ~((next_s.hf_flag & half_full_enable) |
                        (next_s.ovf_flag & overflow_enable) |
                        next_s.smp_pend);
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= MAIN_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign energy_total = s.energy[43:4];
  assign power_offset_trim = s.offset;
  assign pulse_rate_divider = s.pdiv;
  assign waveform_sample = s.wave;
  assign half_full_flag = s.hf_flag;
  assign overflow_flag = s.ovf_flag;
  assign sample_pending = s.smp_pend;
  assign irq_out = s.irq_out;
  assign irq_oe_n = s.irq_oe_n;

  // checks
  a_energy_step: assert property (@(posedge mclk) disable iff (!arst_n)
    upd_tick |=> s.energy == $past(s.energy) + {{20{$past(power_corr[23])}}, $past(power_corr)})
    else $error("energy step not the signed power sample");
  a_energy_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !upd_tick |=> $stable(s.energy) && $stable(s.freq))
    else $error("accumulator moved between updates");
  a_neg_lowers: assert property (@(posedge mclk) disable iff (!arst_n)
    (upd_tick && power_corr[23] && !ovf_now) |=> $signed(s.energy) < $signed($past(s.energy)))
    else $error("negative power did not lower energy");
  a_wrap_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    (upd_tick && ovf_now) |=> s.ovf_flag && (s.energy[43] != $past(s.energy[43])))
    else $error("wrap not flagged");
  a_half_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    (upd_tick && half_now && !s.in_half) |=> s.hf_flag)
    else $error("half-full crossing not flagged");
  a_irq_half: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.hf_flag && $past(half_full_enable)) |-> !s.irq_oe_n)
    else $error("half-full cause not driving request");
  a_irq_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.ovf_flag && $past(overflow_enable)) |-> !s.irq_oe_n)
    else $error("wrap cause not driving request");
  a_irq_sample: assert property (@(posedge mclk) disable iff (!arst_n)
    s.smp_pend |-> !s.irq_oe_n && !s.irq_out)
    else $error("pending sample without interrupt request");
  a_wave_load: assert property (@(posedge mclk) disable iff (!arst_n)
    (smp_tick && waveform_src_sel == `EAF_SRC_POWER && sample_ready_enable) |=>
      s.wave == {{4{$past(power_corr[23])}}, $past(power_corr[23:4])} && s.smp_pend)
    else $error("waveform sample not loaded");
  a_offset_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_offset_trim && upd_tick) |=> s.offset == $past(wr_data)
      && s.energy == $past(s.energy) + {{20{$past(power_corr[23])}}, $past(power_corr)})
    else $error("offset trim write lost");
  a_msb_rise: assert property (@(posedge mclk) disable iff (!arst_n)
    (upd_tick && !s.freq[27] && next_s.freq[27]) |=> s.msb_rise ##1 !s.msb_rise)
    else $error("msb rise not forwarded");
  a_div_reset: assert property (@(posedge mclk)
    $rose(arst_n) |-> s.pdiv == `EAF_PDIV_RST)
    else $error("divider reset value wrong");
  a_energy_rise: assert property (@(posedge mclk) disable iff (!arst_n)
    (upd_tick && !power_corr[23] && power_corr != 24'h000000 && !ovf_now) |=>
      $signed(s.energy) > $signed($past(s.energy)))
    else $error("positive power did not raise energy");
  a_energy_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    (upd_tick && power_corr == 24'h000000) |=> $stable(s.energy))
    else $error("energy moved at zero power");

  // register port checks
  a_trim_load: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_offset_trim |=> s.offset == $past(wr_data))
    else $error("offset trim write not taken");
  a_trim_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !wr_offset_trim |=> $stable(s.offset))
    else $error("offset trim changed without a write");
  a_div_load: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_pulse_divider |=> s.pdiv == $past(wr_data))
    else $error("divider write not taken");
  a_div_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !wr_pulse_divider |=> $stable(s.pdiv))
    else $error("divider changed without a write");
  a_trim_scale: assert property (@(posedge mclk) disable iff (!arst_n)
    power_corr[3:0] == s.offset[3:0])
    else $error("offset trim not at one sixteenth resolution");

  // frequency accumulator and pulse checks
  a_freq_step: assert property (@(posedge mclk) disable iff (!arst_n)
    upd_tick |=> s.freq == $past(s.freq) + {{4{$past(power_corr[23])}}, $past(power_corr)})
    else $error("frequency step not the signed power sample");
  a_msb_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    !upd_tick |=> !s.msb_rise)
    else $error("msb rise outside an update");
  a_msb_edge: assert property (@(posedge mclk) disable iff (!arst_n)
    s.msb_rise |-> s.freq[27] && !$past(s.freq[27]))
    else $error("msb rise without a zero to one change");
  a_cf_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(calibration_pulse_out) |-> $past(s.msb_rise))
    else $error("calibration pulse without msb rise");
  a_cf_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    (!s.msb_rise && !calibration_pulse_out) |=> !calibration_pulse_out)
    else $error("calibration pulse from idle without cause");

  // energy event checks
  a_in_half: assert property (@(posedge mclk) disable iff (!arst_n)
    upd_tick |=> s.in_half == $past(half_now))
    else $error("half-full region not tracked");
  a_hf_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s.hf_flag) |-> $past(upd_tick) && $past(half_now))
    else $error("half-full flag without crossing");
  a_hf_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.hf_flag && !clear_half_full) |=> s.hf_flag)
    else $error("half-full flag dropped without clear");
  a_hf_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (clear_half_full && !upd_tick) |=> !s.hf_flag)
    else $error("half-full flag not cleared");
  a_ovf_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s.ovf_flag) |-> $past(upd_tick) && $past(ovf_now))
    else $error("wrap flag without wrap");
  a_ovf_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.ovf_flag && !clear_overflow) |=> s.ovf_flag)
    else $error("wrap flag dropped without clear");
  a_ovf_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (clear_overflow && !upd_tick) |=> !s.ovf_flag)
    else $error("wrap flag not cleared");

  // waveform and interrupt checks
  a_wave_sext: assert property (@(posedge mclk) disable iff (!arst_n)
    s.wave[23:20] == {4{s.wave[19]}})
    else $error("waveform sample not sign-extended");
  a_wave_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !smp_tick |=> $stable(s.wave))
    else $error("waveform changed off the sample tick");
  a_wave_src: assert property (@(posedge mclk) disable iff (!arst_n)
    (smp_tick && waveform_src_sel != `EAF_SRC_POWER) |=> $stable(s.wave))
    else $error("waveform loaded for another source");
  a_wave_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (smp_tick && !sample_ready_enable) |=> $stable(s.wave))
    else $error("waveform loaded while disabled");
  a_smp_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s.smp_pend) |-> $past(smp_tick) && $past(sample_ready_enable))
    else $error("sample pending without a load");
  a_pend_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.smp_pend && !sample_ack) |=> s.smp_pend)
    else $error("sample pending dropped without ack");
  a_pend_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (sample_ack && !smp_tick) |=> !s.smp_pend)
    else $error("sample pending not cleared by ack");
  a_irq_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    (!s.hf_flag && !s.ovf_flag && !s.smp_pend) |-> s.irq_oe_n)
    else $error("interrupt request without cause");
  a_irq_low: assert property (@(posedge mclk) disable iff (!arst_n)
    !s.irq_out)
    else $error("interrupt line driven high");
  c_overflow: cover property (@(posedge mclk) disable iff (!arst_n) $rose(s.ovf_flag));
  c_half: cover property (@(posedge mclk) disable iff (!arst_n) $rose(s.hf_flag));
  c_sample: cover property (@(posedge mclk) disable iff (!arst_n) $rose(s.smp_pend));
  c_set_clear: cover property (@(posedge mclk) disable iff (!arst_n)
    clear_half_full && upd_tick && half_now && !s.in_half);
endmodule

//--- design/eaf_defs.svh
`ifndef EAF_DEFS_SVH
`define EAF_DEFS_SVH
// master clocks per accumulator update, as last prescaler count
`define EAF_UPD_LAST     2'd3
// pulse divider reset value
`define EAF_PDIV_RST     12'h03f
// fraction bits carried for the offset trim (16 trim lsb = 1 sample lsb)
`define EAF_FRAC_BITS    4
// waveform sample masks in update ticks: 32, 64, 128, 256 updates
`define EAF_WAV_MASK0    8'h1f
`define EAF_WAV_MASK1    8'h3f
`define EAF_WAV_MASK2    8'h7f
`define EAF_WAV_MASK3    8'hff
// waveform source code selecting active power
`define EAF_SRC_POWER    2'h0
`endif

//--- design/eaf_pkg.sv
package eaf_pkg;
  typedef enum logic [0:0] {EAF_CF_IDLE, EAF_CF_HIGH} eaf_cf_state_t;

  typedef struct packed {
    logic [1:0]  pre;
    logic [7:0]  wcnt;
    logic        upd;
    logic        smp;
  } eaf_rate_st_t;

  typedef struct packed {
    eaf_cf_state_t st;
    logic [11:0]   cnt;
    logic [1:0]    hcnt;
    logic          out;
  } eaf_cf_st_t;

  typedef struct packed {
    logic [43:0] energy;
    logic [27:0] freq;
    logic [11:0] offset;
    logic [11:0] pdiv;
    logic        hf_flag;
    logic        ovf_flag;
    logic        in_half;
    logic        msb_rise;
    logic [23:0] wave;
    logic        smp_pend;
    logic        irq_oe_n;
    logic        irq_out;
  } eaf_main_st_t;
endpackage

//--- design/eaf_rate_gen.sv
`timescale 1ns/10ps
`include "eaf_defs.svh"
module eaf_rate_gen
  import eaf_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // rate choice
  input  wire logic [1:0] rate_sel,
  // enables
  output logic            upd_tick,
  output logic            smp_tick
);
  eaf_rate_st_t s;
  eaf_rate_st_t next_s;

  // sample interval mask in update ticks
  function automatic logic [7:0] wav_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    wav_mask = `EAF_WAV_MASK0;
      2'h1:    wav_mask = `EAF_WAV_MASK1;
      2'h2:    wav_mask = `EAF_WAV_MASK2;
      default: wav_mask = `EAF_WAV_MASK3;
    endcase
  endfunction

  // prescaler and sample counter
  always_comb begin
    next_s = s;
    next_s.pre = s.pre + 2'd1;
    next_s.upd = (s.pre == `EAF_UPD_LAST);
    next_s.smp = 1'b0;
    if (s.pre == `EAF_UPD_LAST) begin
      next_s.wcnt = s.wcnt + 8'd1;
      next_s.smp = ((s.wcnt & wav_mask(rate_sel)) == 8'h00);
    end
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign upd_tick = s.upd;
  assign smp_tick = s.smp;

  a_upd_spacing: assert property (@(posedge mclk) disable iff (!arst_n)
    s.upd |=> !s.upd [*3] ##1 s.upd)
    else $error("update tick spacing not four clocks");
  a_smp_on_upd: assert property (@(posedge mclk) disable iff (!arst_n)
    s.smp |-> s.upd)
    else $error("sample tick off the update grid");
endmodule

//--- design/eaf_pulse_div.sv
`timescale 1ns/10ps
`include "eaf_defs.svh"
module eaf_pulse_div
  import eaf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // pulse source and ratio
  input  wire logic        msb_rise,
  input  wire logic [11:0] div_val,
  // divided pulse
  output logic             pulse_out
);
  eaf_cf_st_t s;
  eaf_cf_st_t next_s;

  // count accumulator msb rises, emit one update-long pulse
  always_comb begin
    next_s = s;
    case (s.st)
      EAF_CF_IDLE: begin
        if (msb_rise) begin
          // a divider written below the running count fires on the next rise
          if (s.cnt >= div_val) begin
            next_s.cnt = 12'h000;
            next_s.st = EAF_CF_HIGH;
            next_s.out = 1'b1;
            next_s.hcnt = 2'd0;
          end else begin
            next_s.cnt = s.cnt + 12'd1;
          end
        end
      end
      EAF_CF_HIGH: begin
        next_s.hcnt = s.hcnt + 2'd1;
        if (s.hcnt == `EAF_UPD_LAST) begin
          next_s.st = EAF_CF_IDLE;
          next_s.out = 1'b0;
        end
      end
      default: begin
        next_s = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse_out = s.out;

  a_pulse_width: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s.out) |-> s.out [*4] ##1 !s.out)
    else $error("calibration pulse not one update long");
  a_div_fire: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.st == EAF_CF_IDLE && msb_rise && s.cnt >= div_val) |=> $rose(s.out))
    else $error("pulse missing at divider terminal count");
  a_div_count: assert property (@(posedge mclk) disable iff (!arst_n)
    (s.st == EAF_CF_IDLE && msb_rise && s.cnt < div_val) |=> !s.out && s.cnt == $past(s.cnt) + 12'd1)
    else $error("divider miscounted");
  c_pulse: cover property (@(posedge mclk) disable iff (!arst_n) $rose(s.out));
endmodule

//--- sim/eaf_host_model.sv
`timescale 1ns/10ps
module eaf_host_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // device pins
  input  wire logic irq_out,
  input  wire logic irq_oe_n,
  input  wire logic calibration_pulse_out,
  // observations
  output logic      irq_line_n,
  output int        n_pulse,
  output int        pulse_gap,
  output int        pulse_width
);
  int   cyc;
  int   last_rise;
  logic cf_q;
  // pulled-up open-drain interrupt line
  assign irq_line_n = irq_oe_n ? 1'b1 : irq_out;
  // pulse counter of the calibration rig
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cyc         <= 0;
      last_rise   <= 0;
      cf_q        <= 1'b0;
      n_pulse     <= 0;
      pulse_gap   <= 0;
      pulse_width <= 0;
    end else begin
      cyc  <= cyc + 1;
      cf_q <= calibration_pulse_out;
      if (calibration_pulse_out && !cf_q) begin
        n_pulse   <= n_pulse + 1;
        pulse_gap <= cyc - last_rise;
        last_rise <= cyc;
      end
      if (!calibration_pulse_out && cf_q) begin
        pulse_width <= cyc - last_rise;
      end
    end
  end
endmodule

//--- sim/energy_accumulator_freq_out_tb_top.sv
`timescale 1ns/10ps
module energy_accumulator_freq_out_tb_top;
  import eaf_pkg::*;
  logic               mclk;
  logic               arst_n;
  logic signed [19:0] pwr;
  logic               wr_ot;
  logic               wr_pd;
  logic [11:0]        wr_data;
  logic [1:0]         rate;
  logic               sre;
  logic               clr_hf;
  logic               clr_ov;
  logic               ack;
  logic [1:0]         src;
  logic               ev_en;
  logic [39:0]        energy_total;
  logic [11:0]        power_offset_trim;
  logic [11:0]        pulse_rate_divider;
  logic [23:0]        waveform_sample;
  logic               half_full_flag;
  logic               overflow_flag;
  logic               sample_pending;
  logic               irq_out;
  logic               irq_oe_n;
  logic               cf;
  logic               irq_line_n;
  int                 n_pulse;
  int                 pulse_gap;
  int                 pulse_width;
  int                 n_fail;
  int                 n_tests;
  logic [39:0]        e0;

  eaf_top u_eaf_top (.mclk(mclk), .arst_n(arst_n), .power_lowpass(pwr),
    .wr_offset_trim(wr_ot), .wr_pulse_divider(wr_pd), .wr_data(wr_data),
    .waveform_src_sel(src), .waveform_rate_select(rate), .sample_ready_enable(sre),
    .half_full_enable(ev_en), .overflow_enable(ev_en), .clear_half_full(clr_hf),
    .clear_overflow(clr_ov), .sample_ack(ack), .energy_total(energy_total),
    .power_offset_trim(power_offset_trim), .pulse_rate_divider(pulse_rate_divider),
    .waveform_sample(waveform_sample), .half_full_flag(half_full_flag),
    .overflow_flag(overflow_flag), .sample_pending(sample_pending),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .calibration_pulse_out(cf));
  eaf_host_model u_eaf_host_model (.mclk(mclk), .arst_n(arst_n), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .calibration_pulse_out(cf), .irq_line_n(irq_line_n),
    .n_pulse(n_pulse), .pulse_gap(pulse_gap), .pulse_width(pulse_width));

  // clock
  always #10 mclk = ~mclk;

  task automatic clk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      $display("Error at %0t: %s", $time, m);
      n_fail++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one strobed register write
  task automatic wr_reg(input logic to_div, input logic [11:0] d);
    wr_data = d;
    wr_pd   = to_div;
    wr_ot   = !to_div;
    clk(1);
    wr_pd = 1'b0;
    wr_ot = 1'b0;
    clk(1);
  endtask
  // energy change over n clocks at a steady input
  task automatic e_step(input int n, input logic [39:0] d, input string m);
    clk(8);
    e0 = energy_total;
    clk(n);
    chk(energy_total === e0 + d, m);
  endtask
  task automatic wait_pulses(input int n);
    int c0;
    int i;
    c0 = n_pulse;
    for (i = 0; i < 3000 && n_pulse < c0 + n; i++) clk(1);
    chk(n_pulse >= c0 + n, "calibration pulse missing");
  endtask
  task automatic wait_smp(output time t);
    int i;
    for (i = 0; i < 2100 && sample_pending !== 1'b1; i++) clk(1);
    t = $time;
    chk(sample_pending === 1'b1, "waveform sample missing");
  endtask
  task automatic do_ack;
    ack = 1'b1;
    clk(1);
    ack = 1'b0;
    clk(1);
    chk(irq_line_n === 1'b1 && sample_pending === 1'b0, "sample ack");
  endtask

  task automatic t_reset;
    chk(pulse_rate_divider === 12'h03f, "divider reset");
    chk(energy_total === 40'h0 && irq_line_n === 1'b1, "reset state");
    clr_hf = 1'b1;
    clr_ov = 1'b1;
    clk(1);
    clr_hf = 1'b0;
    clr_ov = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_accum;
    pwr = 20'sd100;
    e_step(16, 40'd400, "energy sum");
    e_step(4, 40'd100, "update rate");
    pwr = -20'sd50;
    e_step(16, -40'sd200, "signed sum");
    chk(half_full_flag === 1'b0 && overflow_flag === 1'b0, "no event");
    $display("test accumulate done");
  endtask
  task automatic t_offset;
    pwr = 20'sd0;
    wr_reg(1'b0, 12'h010);
    chk(power_offset_trim === 12'h010, "offset readback");
    e_step(16, 40'd4, "whole offset");
    wr_reg(1'b0, 12'hff0);
    e_step(16, -40'sd4, "negative offset");
    wr_reg(1'b0, 12'h008);
    e_step(32, 40'd4, "half step offset");
    wr_reg(1'b0, 12'h000);
    $display("test offset done");
  endtask
  // full-scale power wraps the 28-bit sum about every 32 updates
  task automatic t_cf;
    pwr = 20'sh7ffff;
    wr_reg(1'b1, 12'h000);
    chk(pulse_rate_divider === 12'h000, "divider readback");
    wait_pulses(3);
    chk(pulse_width == 4, "pulse width");
    chk(pulse_gap >= 128 && pulse_gap <= 132, "undivided rate");
    wr_reg(1'b1, 12'h002);
    wait_pulses(3);
    chk(pulse_gap >= 384 && pulse_gap <= 400, "divided rate");
    pwr = 20'sd0;
    $display("test pulse done");
  endtask
  task automatic t_wave;
    time t1;
    time t2;
    pwr = -20'sd5;
    sre = 1'b1;
    for (int r = 0; r < 4; r++) begin
      rate = r[1:0];
      wait_smp(t1);
      do_ack();
      wait_smp(t1);
      chk(irq_line_n === 1'b0, "sample interrupt");
      chk(waveform_sample === 24'hfffffb, "sample value");
      do_ack();
      wait_smp(t2);
      chk(t2 - t1 == time'((128 << r) * 20), "sample rate");
      do_ack();
    end
    // another source code or a cleared enable must load nothing
    src = 2'h1;
    clk(1100);
    chk(sample_pending === 1'b0 && irq_line_n === 1'b1, "other source loaded");
    src = 2'h0;
    sre = 1'b0;
    clk(1100);
    chk(sample_pending === 1'b0 && irq_line_n === 1'b1, "disabled sample loaded");
    $display("test waveform done");
  endtask

  // watchdog
  initial begin
    #1000000;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
  // main sequence
  initial begin
    mclk    = 1'b0;
    arst_n  = 1'b0;
    pwr     = 20'sd0;
    wr_ot   = 1'b0;
    wr_pd   = 1'b0;
    wr_data = 12'h000;
    rate    = 2'h0;
    sre     = 1'b0;
    src     = 2'h0;
    ev_en   = 1'b1;
    clr_hf  = 1'b0;
    clr_ov  = 1'b0;
    ack     = 1'b0;
    n_fail  = 0;
    n_tests = 0;
    clk(8);
    arst_n = 1'b1;
    clk(1);
    t_reset();
    t_accum();
    t_offset();
    t_cf();
    t_wave();
    finish_test();
  end
endmodule
